// [design/rcsw_pkg.sv]
// constants, register map and state codes for the reset-cause sequencer
package rcsw_pkg;
   // timing
   localparam int CLK_PERIOD_NS   = 5;
   localparam int WDT_TIME_NS     = 18000000;
   localparam int WDT_CYCLES_DFLT = WDT_TIME_NS / CLK_PERIOD_NS;
   localparam int RST_TIME_NS     = 10000;
   localparam int RST_CYCLES      = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register byte addresses
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_CONFIG  = 8'h08;
   localparam logic [7:0] ADDR_PORT    = 8'h0c;
   localparam logic [7:0] ADDR_WDOG    = 8'h10;
   // status bits
   localparam int ST_CWF   = 7;
   localparam int ST_PWF   = 6;
   localparam int ST_TO    = 4;
   localparam int ST_PD    = 3;
   localparam int ST_PROG  = 1;
   localparam int ST_SLEEP = 0;
   // control and config bits
   localparam int CTL_SLEEP     = 0;
   localparam int CTL_CLRWDT    = 1;
   localparam int CFG_WDT_EN    = 0;
   localparam int CFG_EXTERNAL_RESET_PIN_EN   = 1;
   localparam int CFG_PIN_WAKE  = 2;
   localparam int CFG_CMP_WAKE  = 3;
   localparam int CFG_CODE_PROT = 4;
   localparam int CFG_W         = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 5'h03;
   localparam int PORT_OEN_LSB  = 8;
   // pins and synchroniser lanes
   localparam logic [3:0] WAKE_PINS = 4'hb;
   localparam int SY_RST  = 4;
   localparam int SY_CMP  = 5;
   localparam int SY_PROG = 6;
   localparam int NSYNC   = 7;
   localparam logic [NSYNC-1:0] SYNC_INIT = 7'h10;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SDAT = 0;
   // program mode
   localparam int CP_OPEN_WORDS = 64;
   localparam int ID_WORDS      = 4;
   localparam int CMD_BITS      = 6;
   localparam int DATA_BITS     = 16;
   localparam logic [CMD_BITS-1:0] CMD_LOAD = 6'h02;
   localparam logic [CMD_BITS-1:0] CMD_READ = 6'h04;
   localparam logic [CMD_BITS-1:0] CMD_INC  = 6'h06;
   typedef enum logic [1:0] {
      S_RUN   = 2'b00,
      S_SLEEP = 2'b01,
      S_WAKE  = 2'b11,
      S_PROG  = 2'b10
   } seq_state_t;
   typedef enum logic [1:0] {
      PH_CMD  = 2'b00,
      PH_LOAD = 2'b01,
      PH_READ = 2'b11
   } ser_phase_t;
endpackage

// [design/reset_cause_sleep_wake.sv]
// reset-cause flags, sleep and wake control, serial program mode
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: watchdog wake from sleep clears all four cause flags.
// RULE_02: watchdog timeout awake clears timeout and wake flags, keeps powerdown.
// RULE_03: reset pin wake sets timeout, clears powerdown and both wake flags.
// RULE_04: reset pin while awake clears wake flags, keeps timeout and powerdown.
// RULE_05: power-up sets timeout and powerdown, clears both wake flags.
// RULE_06: pin-change wake sets pin-wake and timeout, clears powerdown and comparator-wake.
// RULE_07: comparator wake sets comparator-wake and timeout, clears powerdown and pin-wake.
// RULE_08: flags hold until next reset event or sleep entry; nothing else alters them.
// RULE_09: sleep clears running watchdog, sets timeout, clears powerdown, stops clock.
// RULE_10: port outputs and enables keep their state throughout sleep.
// RULE_11: watchdog reset stays internal; reset pin is never driven.
// RULE_12: sleep ends by full reset from reset pin, watchdog, pins or comparator.
// RULE_13: enabled pins 0, 1, 3 wake when differing from last read snapshot.
// RULE_14: unread port after pin wake makes the next sleep wake immediately.
// RULE_15: pin-wake records pin change, comparator-wake records comparator change in sleep.
// RULE_16: watchdog counter is cleared on every wake from sleep.
// RULE_17: program read-out blocked by protection except first 64 and last word.
// RULE_18: four ID words, reachable only in program mode, read and write.
// RULE_19: programmer should use low 4 ID bits, upper 8 bits zero.
// RULE_20: pins 1 and 0 low while programming level rises enters program mode.
// RULE_21: each transfer is a 6-bit command then 16 data bits; here only load and read commands are followed by 16 data bits.
// RULE_22: watchdog keeps counting on its own while processor clock stops.
// RULE_23: snapshot recaptured on every port access, compared continuously in sleep.
module reset_cause_sleep_wake
   import rcsw_pkg::*;
#(
   parameter int WDT_CYCLES = WDT_CYCLES_DFLT,
   parameter int PMEM_DEPTH = 256,
   parameter int WORD_W     = DATA_BITS
)(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // avalon-mm slave
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   // device pins
   input  wire logic [3:0]  port_pins_i,
   input  wire logic        ext_reset_n_i,
   input  wire logic        cmp_i,
   input  wire logic        prog_level_i,
   output logic [3:0]       port_o,
   output logic [3:0]       port_oe_n_o,
   output logic             sdata_o,
   output logic             sdata_oe_n_o,
   output logic             reset_pin_oe_n_o,
   // processor core
   output logic             core_reset_o,
   output logic             core_clk_en_o
);
   localparam int MDEPTH = PMEM_DEPTH + ID_WORDS;
   localparam int AW     = $clog2(MDEPTH);
   localparam int WW     = $clog2(WDT_CYCLES + 1);
   localparam int RW     = $clog2(RST_CYCLES + 1);
   localparam int CW     = $clog2(DATA_BITS + 1);
   localparam logic [AW-1:0] LAST_PROG = AW'(PMEM_DEPTH - 1);
   localparam logic [AW-1:0] LAST_ID   = AW'(MDEPTH - 1);
   localparam logic [AW-1:0] OPEN_LIM  = AW'(CP_OPEN_WORDS);
   localparam logic [WW-1:0] WDT_LAST  = WW'(WDT_CYCLES - 1);
   localparam logic [RW-1:0] RST_LAST  = RW'(RST_CYCLES - 1);
   localparam logic [CW-1:0] CMD_LAST  = CW'(CMD_BITS - 1);
   localparam logic [CW-1:0] DATA_LAST = CW'(WORD_W - 1);
   localparam logic [CW-1:0] DATA_END  = CW'(WORD_W);

   seq_state_t          state_q, state_d;
   ser_phase_t          phase_q, phase_d;
   logic [NSYNC-1:0]    meta_q, sync_q, prev_q;
   logic                to_q, pd_q, pwf_q, cwf_q;
   logic                to_d, pd_d, pwf_d, cwf_d;
   logic [CFG_W-1:0]    cfg_q;
   logic [3:0]          snap_q, port_q, port_oen_q;
   logic                cmp_snap_q;
   logic [WW-1:0]       wdt_q;
   logic [RW-1:0]       rst_cnt_q;
   logic                wait_q;
   logic [31:0]         readdata_q;
   logic [CW-1:0]       cnt_q, cnt_d;
   logic [CMD_BITS-1:0] cmd_q, cmd_d;
   logic [WORD_W-1:0]   shift_q, shift_d;
   logic [WORD_W-1:0]   mem_rdata;
   logic [AW-1:0]       addr_q, addr_d;
   logic                sdo_q, sdo_d, sdo_oen_q;
   logic                mem_we, rst_pin_oen_q;
   logic                core_reset_q, core_clk_en_q;

   // pin synchronisers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= SYNC_INIT;
         sync_q <= SYNC_INIT;
         prev_q <= SYNC_INIT;
      end else begin
         meta_q <= {prog_level_i, cmp_i, ext_reset_n_i, port_pins_i};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   wire [3:0] pins     = sync_q[3:0];
   wire       in_run   = state_q == S_RUN;
   wire       in_sleep = state_q == S_SLEEP;
   wire       in_prog  = state_q == S_PROG;
   wire       awake_or_asleep = in_run | in_sleep;
   wire       external_reset_pin_en  = cfg_q[CFG_EXTERNAL_RESET_PIN_EN];
   wire       external_reset_pin_low = external_reset_pin_en & ~sync_q[SY_RST];
   wire       external_reset_pin_fall = external_reset_pin_en & prev_q[SY_RST] & ~sync_q[SY_RST];
   wire       sclk_rise = in_prog & sync_q[PIN_SCLK] & ~prev_q[PIN_SCLK];
   wire       sclk_fall = in_prog & ~sync_q[PIN_SCLK] & prev_q[PIN_SCLK];
   wire       sdat      = sync_q[PIN_SDAT];
   wire       prog_fall = prev_q[SY_PROG] & ~sync_q[SY_PROG];
   // RULE_20 program mode entry
   wire       prog_entry = ~in_prog & sync_q[SY_PROG] & ~prev_q[SY_PROG]
                           & ~pins[PIN_SCLK] & ~pins[PIN_SDAT];
   // RULE_13 wake pin compare
   wire [3:0] wake_mask = WAKE_PINS & {~external_reset_pin_en, 3'h7};
   // RULE_14 stale snapshot wakes
   wire       pin_evt = cfg_q[CFG_PIN_WAKE] & (|((pins ^ snap_q) & wake_mask));
   wire       cmp_evt = cfg_q[CFG_CMP_WAKE] & (sync_q[SY_CMP] ^ cmp_snap_q);
   wire       wdt_evt = cfg_q[CFG_WDT_EN] & (wdt_q == WDT_LAST);
   // RULE_12 wake sources by priority
   wire       w_external_reset_pin = external_reset_pin_fall & awake_or_asleep;
   wire       w_wdt  = ~w_external_reset_pin & wdt_evt & awake_or_asleep;
   wire       w_pin  = ~w_external_reset_pin & ~w_wdt & in_sleep & pin_evt;
   wire       w_cmp  = ~w_external_reset_pin & ~w_wdt & ~w_pin & in_sleep & cmp_evt;
   wire       any_reset = w_external_reset_pin | w_wdt | w_pin | w_cmp;

   // bus decode
   wire       bus_go   = (read_i | write_i) & ~wait_q;
   wire       wr_go    = write_i & bus_go;
   wire       hit_stat = address_i == ADDR_STATUS;
   wire       hit_ctl  = address_i == ADDR_CONTROL;
   wire       hit_cfg  = address_i == ADDR_CONFIG;
   wire       hit_port = address_i == ADDR_PORT;
   wire       hit_wdog = address_i == ADDR_WDOG;
   wire       sleep_cmd  = wr_go & hit_ctl & writedata_i[CTL_SLEEP] & in_run & ~any_reset;
   wire       clrwdt_cmd = wr_go & hit_ctl & writedata_i[CTL_CLRWDT];
   wire       port_wr    = wr_go & hit_port & in_run;
   // RULE_23 port access recapture
   wire       port_touch = bus_go & hit_port;
   wire [31:0] status_w = (32'(cwf_q) << ST_CWF) | (32'(pwf_q) << ST_PWF)
                        | (32'(to_q) << ST_TO) | (32'(pd_q) << ST_PD)
                        | (32'(in_prog) << ST_PROG) | (32'(in_sleep) << ST_SLEEP);
   wire [31:0] port_w = (32'(port_oen_q) << PORT_OEN_LSB) | 32'(pins);
   wire [31:0] rd_mux = hit_stat ? status_w :
                        hit_cfg  ? 32'(cfg_q) :
                        hit_port ? port_w :
                        hit_wdog ? 32'(wdt_q) : 32'h0000_0000;

   // cause flags next value
   always_comb begin
      {to_d, pd_d, pwf_d, cwf_d} = {to_q, pd_q, pwf_q, cwf_q};
      if (w_external_reset_pin) begin
         // RULE_04 reset pin clears wakes
         pwf_d = 1'b0;
         cwf_d = 1'b0;
         if (in_sleep) begin
            // RULE_03 reset pin wake
            to_d = 1'b1;
            pd_d = 1'b0;
         end
      end else if (w_wdt) begin
         // RULE_02 watchdog timeout flags
         to_d  = 1'b0;
         pwf_d = 1'b0;
         cwf_d = 1'b0;
         if (in_sleep) begin
            // RULE_01 watchdog wake clears all
            pd_d = 1'b0;
         end
      end else if (w_pin) begin
         // RULE_06 pin wake flags
         {to_d, pd_d, pwf_d, cwf_d} = 4'ha;
      end else if (w_cmp) begin
         // RULE_07 comparator wake flags
         {to_d, pd_d, pwf_d, cwf_d} = 4'h9;
      end else if (sleep_cmd) begin
         // RULE_09 sleep entry flags
         to_d = 1'b1;
         pd_d = 1'b0;
      end
   end

   // RULE_08 flags hold between events
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // RULE_05 power-up values
         {to_q, pd_q, pwf_q, cwf_q} <= 4'hc;
      end else begin
         {to_q, pd_q, pwf_q, cwf_q} <= {to_d, pd_d, pwf_d, cwf_d};
      end
   end

   // sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_RUN: begin
            if (any_reset) begin
               state_d = S_WAKE;
            end else if (sleep_cmd) begin
               state_d = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (any_reset) begin
               state_d = S_WAKE;
            end
         end
         S_WAKE: begin
            if (rst_cnt_q == RST_LAST && !external_reset_pin_low) begin
               state_d = S_RUN;
            end
         end
         S_PROG: begin
            if (prog_fall) begin
               state_d = S_WAKE;
            end
         end
      endcase
      if (prog_entry) begin
         state_d = S_PROG;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q   <= S_WAKE;
         rst_cnt_q <= '0;
      end else begin
         state_q   <= state_d;
         rst_cnt_q <= (state_q == S_WAKE && rst_cnt_q != RST_LAST) ? rst_cnt_q + 1'b1 : '0;
      end
   end

   // RULE_22 watchdog runs through sleep
   // RULE_16 cleared on wake
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdt_q <= '0;
      end else if (sleep_cmd || clrwdt_cmd || any_reset || !awake_or_asleep
                   || !cfg_q[CFG_WDT_EN]) begin
         wdt_q <= '0;
      end else begin
         wdt_q <= wdt_q + 1'b1;
      end
   end

   // configuration, ports and snapshots
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q      <= CFG_RESET;
         port_q     <= '0;
         port_oen_q <= '1;
         snap_q     <= '0;
         cmp_snap_q <= 1'b0;
      end else begin
         if (wr_go && hit_cfg && in_run) begin
            cfg_q <= writedata_i[CFG_W-1:0];
         end
         // RULE_10 ports written only awake; enables forced high entering reset or program mode
         if (state_d == S_WAKE || state_d == S_PROG) begin
            port_oen_q <= '1;
         end else if (port_wr) begin
            port_q     <= writedata_i[3:0];
            port_oen_q <= writedata_i[PORT_OEN_LSB +: 4];
         end
         // RULE_15 change references
         if (port_touch) begin
            snap_q <= pins;
         end
         if (sleep_cmd) begin
            cmp_snap_q <= sync_q[SY_CMP];
         end
      end
   end

   // RULE_17 code protection gate
   wire readable = ~cfg_q[CFG_CODE_PROT] | (addr_q < OPEN_LIM)
                   | (addr_q == LAST_PROG) | (addr_q > LAST_PROG);
   wire [CMD_BITS-1:0] cmd_in   = {sdat, cmd_q[CMD_BITS-1:1]};
   wire [WORD_W-1:0]   shift_in = {sdat, shift_q[WORD_W-1:1]};

   // RULE_21 command then data framing
   always_comb begin
      phase_d = phase_q;
      cnt_d   = cnt_q;
      cmd_d   = cmd_q;
      shift_d = shift_q;
      addr_d  = addr_q;
      sdo_d   = sdo_q;
      mem_we  = 1'b0;
      if (!in_prog) begin
         phase_d = PH_CMD;
         cnt_d   = '0;
         addr_d  = '0;
      end else if (sclk_rise) begin
         unique case (phase_q)
            PH_CMD: begin
               cmd_d = cmd_in;
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == CMD_LAST) begin
                  cnt_d = '0;
                  if (cmd_in == CMD_LOAD) begin
                     phase_d = PH_LOAD;
                  end else if (cmd_in == CMD_READ) begin
                     phase_d = PH_READ;
                     shift_d = readable ? mem_rdata : '0;
                     sdo_d   = 1'b0;
                  end else if (cmd_in == CMD_INC) begin
                     addr_d = (addr_q == LAST_ID) ? '0 : addr_q + 1'b1;
                  end
               end
            end
            PH_LOAD: begin
               shift_d = shift_in;
               cnt_d   = cnt_q + 1'b1;
               if (cnt_q == DATA_LAST) begin
                  // RULE_18 id and program words written
                  mem_we  = 1'b1;
                  phase_d = PH_CMD;
                  cnt_d   = '0;
               end
            end
            PH_READ: begin
               if (cnt_q != DATA_END) begin
                  sdo_d   = shift_q[0];
                  shift_d = shift_q >> 1;
                  cnt_d   = cnt_q + 1'b1;
               end
            end
            default: begin
               phase_d = PH_CMD;
            end
         endcase
      end else if (sclk_fall && phase_q == PH_READ && cnt_q == DATA_END) begin
         phase_d = PH_CMD;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase_q <= PH_CMD;
         cnt_q   <= '0;
         cmd_q   <= '0;
         shift_q <= '0;
         addr_q  <= '0;
         sdo_q   <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q   <= cnt_d;
         cmd_q   <= cmd_d;
         shift_q <= shift_d;
         addr_q  <= addr_d;
         sdo_q   <= sdo_d;
      end
   end

   word_mem #(
      .DEPTH (MDEPTH),
      .WIDTH (WORD_W),
      .AW    (AW)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .addr_i  (addr_q),
      .wdata_i (shift_in),
      .rdata_o (mem_rdata)
   );

   // bus answer and registered outputs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_q        <= 1'b1;
         readdata_q    <= '0;
         sdo_oen_q     <= 1'b1;
         rst_pin_oen_q <= 1'b1;
         core_reset_q  <= 1'b1;
         core_clk_en_q <= 1'b0;
      end else begin
         wait_q        <= ~((read_i | write_i) & wait_q);
         // load when the request is first seen so data stand as waitrequest drops
         if (read_i && wait_q) begin
            readdata_q <= rd_mux;
         end
         sdo_oen_q     <= ~(in_prog && phase_d == PH_READ);
         // RULE_11 reset pin never driven
         rst_pin_oen_q <= 1'b1;
         core_reset_q  <= state_d == S_WAKE || state_d == S_PROG;
         core_clk_en_q <= state_d == S_RUN;
      end
   end

   assign readdata_o       = readdata_q;
   assign waitrequest_o    = wait_q;
   assign port_o           = port_q;
   assign port_oe_n_o      = port_oen_q;
   assign sdata_o          = sdo_q;
   assign sdata_oe_n_o     = sdo_oen_q;
   assign reset_pin_oe_n_o = rst_pin_oen_q;
   assign core_reset_o     = core_reset_q;
   assign core_clk_en_o    = core_clk_en_q;

   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_wdt_sleep_wake: assert property ( // RULE_01
      in_sleep && w_wdt |=> !to_q && !pd_q && !pwf_q && !cwf_q && core_reset_o)
      else $error("watchdog wake flags wrong");
   a_wdt_awake: assert property ( // RULE_02
      in_run && w_wdt |=> !to_q && pd_q == $past(pd_q) && !pwf_q && !cwf_q)
      else $error("watchdog timeout flags wrong");
   a_external_reset_pin_sleep: assert property ( // RULE_03
      in_sleep && w_external_reset_pin |=> to_q && !pd_q && !pwf_q && !cwf_q)
      else $error("reset pin wake flags wrong");
   a_external_reset_pin_awake: assert property ( // RULE_04
      in_run && w_external_reset_pin |=> $stable(to_q) && $stable(pd_q) && !pwf_q && !cwf_q)
      else $error("reset pin awake flags wrong");
   a_pin_wake: assert property ( // RULE_06
      w_pin |=> pwf_q && to_q && !pd_q && !cwf_q ##1 state_q == S_WAKE)
      else $error("pin wake flags wrong");
   a_cmp_wake: assert property ( // RULE_07
      w_cmp |=> cwf_q && to_q && !pd_q && !pwf_q)
      else $error("comparator wake flags wrong");
   a_flags_hold: assert property ( // RULE_08
      !any_reset && !sleep_cmd |=> $stable({to_q, pd_q, pwf_q, cwf_q}))
      else $error("cause flags moved without event");
   a_sleep_entry: assert property ( // RULE_09
      sleep_cmd |=> to_q && !pd_q && wdt_q == '0 ##1 !core_clk_en_o)
      else $error("sleep entry wrong");
   a_port_hold: assert property ( // RULE_10
      in_sleep && state_d == S_SLEEP |=> $stable(port_o) && $stable(port_oe_n_o))
      else $error("port changed during sleep");
   a_pin_free: assert property ( // RULE_11
      reset_pin_oe_n_o)
      else $error("reset pin driven");
   a_wake_clear: assert property ( // RULE_16
      in_sleep && any_reset |=> wdt_q == '0 && state_q == S_WAKE)
      else $error("wake did not clear watchdog");
   a_prot_read: assert property ( // RULE_17
      sclk_rise && phase_q == PH_CMD && cnt_q == CMD_LAST && cmd_in == CMD_READ
      && !readable |=> shift_q == '0)
      else $error("protected word read out");
   a_prog_entry: assert property ( // RULE_20
      prog_entry |=> in_prog ##1 core_reset_o && !core_clk_en_o)
      else $error("program mode entry wrong");
endmodule

// [design/word_mem.sv]
// small synchronous word memory with registered read data
`timescale 1ns/1ps
module word_mem #(
   parameter int DEPTH = 260,
   parameter int WIDTH = 16,
   parameter int AW    = 9
)(
   // clock
   input  wire logic             clk_i,
   // shared address, write port
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    addr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // read port
   output logic [WIDTH-1:0]      rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rdata_q;

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_q <= mem_q[addr_i];
   end

   assign rdata_o = rdata_q;
endmodule

// [testbench/prog_model.sv]
// serial programmer and pin model on the far side of the device
`timescale 1ns/1ps
module prog_model
   import rcsw_pkg::*;
(
   // device serial data
   input  wire logic       sdata_i,
   input  wire logic       sdata_oe_n_i,
   // pins seen by the device
   output logic [3:0]      pins_o,
   output logic            prog_level_o
);
   logic [3:0] drv_q;
   logic       sclk_q;
   logic       dat_q;
   logic       prog_q;
   initial begin
      drv_q = 4'h0;
      sclk_q = 1'b0;
      dat_q = 1'b0;
      prog_q = 1'b0;
   end
   assign prog_level_o = prog_q;
   // clock on pin 1, data on pin 0
   assign pins_o = prog_q ? {drv_q[3:2], sclk_q, sdata_oe_n_i ? dat_q : sdata_i} : drv_q;
   // pins 1 and 0 low while the level rises
   task automatic enter(input logic on);
      drv_q = 4'h0;
      #100 prog_q = on;
   endtask
   // command first, then 16 data bits except after an increment command, lsb first
   task automatic xfer(input logic [5:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
      rd = 16'h0;
      for (int i = 0; i < 22; i++) begin
         if (i == 6 && cmd == CMD_INC) break;
         dat_q = (i < 6) ? cmd[i] : wd[i-6];
         #62.5 sclk_q = 1'b1;
         #62.5 sclk_q = 1'b0;
         if (i >= 6) rd[i-6] = sdata_i;
      end
      #62.5 dat_q = 1'b0;
   endtask
endmodule

// [testbench/reset_cause_sleep_wake_tb.sv]
// directed bench for reset cause, sleep, wake and program mode
`timescale 1ns/1ps
module reset_cause_sleep_wake_tb
   import rcsw_pkg::*;
;
   logic clk_i = 1'b0, arst_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
   logic [7:0]  address_i = 8'h00;
   logic [31:0] writedata_i = 32'h0, readdata_o, q;
   logic waitrequest_o, ext_reset_n_i = 1'b1, cmp_i = 1'b0, prog_level_i;
   logic sdata_o, sdata_oe_n_o, reset_pin_oe_n_o, core_reset_o, core_clk_en_o;
   logic [3:0]  port_pins_i, port_o, port_oe_n_o;
   logic [15:0] sd;
   int bad_count = 0, check_count = 0;
   reset_cause_sleep_wake #(.WDT_CYCLES(200), .PMEM_DEPTH(8)) reset_cause_sleep_wake_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .port_pins_i(port_pins_i), .ext_reset_n_i(ext_reset_n_i),
      .cmp_i(cmp_i), .prog_level_i(prog_level_i), .port_o(port_o), .port_oe_n_o(port_oe_n_o),
      .sdata_o(sdata_o), .sdata_oe_n_o(sdata_oe_n_o), .reset_pin_oe_n_o(reset_pin_oe_n_o),
      .core_reset_o(core_reset_o), .core_clk_en_o(core_clk_en_o));
   prog_model prog_model_i (.sdata_i(sdata_o), .sdata_oe_n_i(sdata_oe_n_o),
      .pins_o(port_pins_i), .prog_level_o(prog_level_i));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic conclude();
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address_i <= a;
      writedata_i <= d;
      write_i <= wr;
      read_i <= !wr;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, q);
   endtask
   task automatic run();
      int n;
      n = 0;
      while (core_clk_en_o !== 1'b0 && n < 6000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 6000) chk("reset", 32'h1, 32'h0);
      while (core_clk_en_o !== 1'b1 && n < 12000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 12000) chk("run", 32'h1, 32'h0);
   endtask
   task automatic nap(input logic [31:0] cfg);
      bus(1'b1, ADDR_CONFIG, cfg);
      bus(1'b1, ADDR_CONTROL, 32'h1);
      repeat (10) @(posedge clk_i);
   endtask
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      run();
      rd("status", ADDR_STATUS, 32'h18);
      chk("rst_oe", 32'h1, {31'h0, reset_pin_oe_n_o});
      run();
      rd("status", ADDR_STATUS, 32'h08);
      bus(1'b1, ADDR_PORT, 32'h5);
      nap(32'h3);
      rd("status", ADDR_STATUS, 32'h11);
      chk("port", 32'h5, {24'h0, port_oe_n_o, port_o});
      chk("clk_en", 32'h0, {31'h0, core_clk_en_o});
      run();
      rd("status", ADDR_STATUS, 32'h00);
      rd("unmapped", 8'h20, 32'h0);
      bus(1'b0, ADDR_PORT, 32'h0);
      nap(32'h6);
      prog_model_i.drv_q <= 4'h1;
      run();
      rd("status", ADDR_STATUS, 32'h50);
      nap(32'h6);
      run();
      rd("status", ADDR_STATUS, 32'h50);
      ext_reset_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ext_reset_n_i <= 1'b1;
      run();
      rd("status", ADDR_STATUS, 32'h10);
      nap(32'ha);
      cmp_i <= 1'b1;
      run();
      rd("status", ADDR_STATUS, 32'h90);
      nap(32'h2);
      ext_reset_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ext_reset_n_i <= 1'b1;
      run();
      rd("status", ADDR_STATUS, 32'h10);
      chk("rst_oe", 32'h1, {31'h0, reset_pin_oe_n_o});
      prog_model_i.enter(1'b1);
      repeat (10) @(posedge clk_i);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("prog", 32'h1, {31'h0, q[ST_PROG]});
      prog_model_i.xfer(CMD_LOAD, 16'h1234, sd);
      prog_model_i.xfer(CMD_READ, 16'h0, sd);
      chk("word0", 32'h1234, {16'h0, sd});
      for (int i = 0; i < 8; i++) prog_model_i.xfer(CMD_INC, 16'h0, sd);
      prog_model_i.xfer(CMD_LOAD, 16'h000a, sd);
      prog_model_i.xfer(CMD_READ, 16'h0, sd);
      chk("id0", 32'h000a, {16'h0, sd});
      prog_model_i.enter(1'b0);
      @(posedge clk_i);
      run();
      conclude();
   end
endmodule
